//--- dec_daw_core.sv
// Decrement-file and decimal-adjust datapath with APB register access.
// Assumes a single pclk domain and a synchronous file memory with 1-cycle read.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps

// Functional notes
// - Decrement reads addressed file register, subtracts one, sends result to destination.
// - Destination bit zero: result goes to accumulator, file register untouched.
// - Destination bit one: result written back to the same file register.
// - Bank-access bit zero: fixed access bank used, bank select ignored.
// - Bank-access bit one: address uses the bank select register.
module dec_adj_core
  import dec_adj_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // File memory
  output fmem_req_t fmem_req,
  input wire logic [DATA_W-1:0] fmem_rdata,
  // Status
  output logic busy
);

  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} state_t;

  state_t state_reg;
  dec_instr_t instr_reg;
  op_t op_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [BANK_W-1:0] bank_select_register;
  logic carry_reg;
  logic digit_carry_flag;
  logic done_reg;
  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] adj_out;
  logic adj_carry;
  logic [ADDR_W-1:0] full_addr;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic go;
  logic [DATA_W-1:0] last_result_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero-wait slave: every access completes in its access phase
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_OPER) || (paddr == OFF_ACC)
                || (paddr == OFF_BANK) || (paddr == OFF_FLAGS) || (paddr == OFF_STAT);
  // Starting an op while busy is dropped, so software must poll status
  assign go = apb_wr && addr_ok && (paddr == OFF_CTRL) && pwdata[CTRL_GO]
           && (state_reg == S_IDLE);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // bank choice
  bank_addr_gen u_bank
  (
    .use_bank(instr_reg.use_bank),
    .bank_sel(bank_select_register),
    .faddr(instr_reg.faddr),
    .full_addr(full_addr)
  );

  bcd_adjust u_bcd
  (
    .din(acc_reg),
    .carry_in(carry_reg),
    .digit_carry_flag(digit_carry_flag),
    .dout(adj_out),
    .carry_out(adj_carry)
  );

  assign diff = fmem_rdata - DEC_STEP;

  // ----------------------------------------------------------------
  // Instruction registers
  // ----------------------------------------------------------------
  // Operand fields held while an op runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_reg <= '{dest_file: 1'b1, use_bank: 1'b1, faddr: 8'h00};
      op_reg <= OP_DEC;
    end
    else if (apb_wr && paddr == OFF_OPER && state_reg == S_IDLE)
    begin
      instr_reg.faddr <= pwdata[FADDR_W-1:0];
      instr_reg.dest_file <= pwdata[OPER_D];
      instr_reg.use_bank <= pwdata[OPER_A];
    end
    else if (go)
      op_reg <= pwdata[CTRL_OP] ? OP_ADJ : OP_DEC;
  end

  // Bank select register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bank_select_register <= BANK_RST;
    else if (apb_wr && paddr == OFF_BANK)
      bank_select_register <= pwdata[BANK_W-1:0];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Decimal adjust needs no memory, so it finishes straight from idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= S_IDLE;
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (go && !pwdata[CTRL_OP])
            state_reg <= S_READ;
        end
        S_READ: state_reg <= S_WRITE;
        S_WRITE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  // Read issued on entry to S_READ; data valid in S_WRITE
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fmem_req <= '0;
    else if (go && !pwdata[CTRL_OP])
      fmem_req <= '{we: 1'b0, addr: full_addr, wdata: ACC_RST};
    else if (state_reg == S_WRITE && instr_reg.dest_file)
      // write back to source
      // Reuses the held read address; a bank write mid-op cannot move it
      fmem_req <= '{we: 1'b1, addr: fmem_req.addr, wdata: diff};
    else
      fmem_req.we <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  // Software writes win only when no op updates the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_reg <= ACC_RST;
    else if (state_reg == S_WRITE && !instr_reg.dest_file)
      acc_reg <= diff;
    else if (go && pwdata[CTRL_OP])
      acc_reg <= adj_out;
    else if (apb_wr && paddr == OFF_ACC)
      acc_reg <= pwdata[DATA_W-1:0];
  end

  // Carry flags; adjust leaves digit carry alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_reg <= 1'b0;
      digit_carry_flag <= 1'b0;
    end
    else if (go && pwdata[CTRL_OP])
      carry_reg <= adj_carry;
    else if (apb_wr && paddr == OFF_FLAGS)
    begin
      carry_reg <= pwdata[FL_C];
      digit_carry_flag <= pwdata[FL_DC];
    end
  end

  // Last result and completion flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_result_reg <= ACC_RST;
      done_reg <= 1'b0;
    end
    else if (state_reg == S_WRITE)
    begin
      last_result_reg <= diff;
      done_reg <= 1'b1;
    end
    else if (go)
    begin
      last_result_reg <= pwdata[CTRL_OP] ? adj_out : last_result_reg;
      done_reg <= pwdata[CTRL_OP];
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  // Read data latched in setup so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd)
      begin
        case (paddr)
          OFF_CTRL: prdata <= {31'h0, op_reg == OP_ADJ};
          OFF_OPER: prdata <= {22'h0, instr_reg.use_bank, instr_reg.dest_file,
                               instr_reg.faddr};
          OFF_ACC: prdata <= {24'h0, acc_reg};
          OFF_BANK: prdata <= {28'h0, bank_select_register};
          OFF_FLAGS: prdata <= {30'h0, digit_carry_flag, carry_reg};
          OFF_STAT: prdata <= {22'h0, done_reg, state_reg != S_IDLE, last_result_reg};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Busy flag from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else
      busy <= (go && !pwdata[CTRL_OP]) || (state_reg == S_READ);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Decrement results
  chk_dec_wb: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == S_WRITE && instr_reg.dest_file) |=> (fmem_req.we
      && fmem_req.wdata == $past(fmem_rdata) - DEC_STEP))
    else $error("write back value wrong");
  chk_dec_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == S_WRITE && !instr_reg.dest_file) |=> (!fmem_req.we
      && acc_reg == $past(fmem_rdata) - DEC_STEP))
    else $error("accumulator result wrong");
  chk_seq_len: assert property (@(posedge pclk) disable iff (!presetn)
    (go && !pwdata[CTRL_OP]) |=> state_reg == S_READ ##1 state_reg == S_WRITE
      ##1 state_reg == S_IDLE)
    else $error("decrement sequence length wrong");
  // Bank addressing
  chk_access_bank: assert property (@(posedge pclk) disable iff (!presetn)
    !instr_reg.use_bank |-> full_addr[ADDR_W-1:FADDR_W] ==
      (instr_reg.faddr < ACCESS_SPLIT ? ACCESS_BANK : ACCESS_HIGH_BANK))
    else $error("access bank not used");
  chk_sel_bank: assert property (@(posedge pclk) disable iff (!presetn)
    instr_reg.use_bank |-> full_addr == {bank_select_register, instr_reg.faddr})
    else $error("bank select not used");
  // Decimal adjust
  chk_adj_lo: assert property (@(posedge pclk) disable iff (!presetn)
    (go && pwdata[CTRL_OP] && acc_reg[3:0] > BCD_MAX) |=>
      acc_reg[3:0] == $past(acc_reg[3:0]) + BCD_FIX)
    else $error("low nibble not adjusted");
  chk_adj_carry: assert property (@(posedge pclk) disable iff (!presetn)
    (go && pwdata[CTRL_OP] && carry_reg) |=> carry_reg)
    else $error("carry lost on adjust");
  chk_file_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == S_WRITE && !instr_reg.dest_file) |=> !fmem_req.we [*2])
    else $error("file written with acc dest");
  // Write-back must hit the word that was read, even if bank select moved
  chk_wb_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == S_WRITE && instr_reg.dest_file) |=> (fmem_req.addr
      == $past(fmem_req.addr)))
    else $error("write back address moved");
  // Status pin tracks the sequencer, high from go until the sequencer leaves S_WRITE
  chk_busy_level: assert property (@(posedge pclk) disable iff (!presetn)
    busy == (state_reg != S_IDLE))
    else $error("busy flag out of step");

endmodule : dec_adj_core

//--- dec_daw_pkg.sv
// Package: constants and carriers for the decrement / decimal-adjust datapath.
// Assumes an 8-bit file register space of 16 banks and an APB register front end.
package dec_adj_pkg;

  // ----------------------------------------------------------------
  // Data and address widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int FADDR_W = 8;
  localparam int ADDR_W = 12;
  localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
  localparam logic [FADDR_W-1:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DEC_STEP = 8'h01;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPER = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;

  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP = 1;
  localparam int OPER_D = 8;
  localparam int OPER_A = 9;
  localparam int FL_C = 0;
  localparam int FL_DC = 1;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;

  // Operation select
  typedef enum logic {OP_DEC, OP_ADJ} op_t;

  // Instruction fields carried as one unit
  typedef struct packed {
    logic dest_file;
    logic use_bank;
    logic [FADDR_W-1:0] faddr;
  } dec_instr_t;

  // File memory request
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fmem_req_t;

endpackage : dec_adj_pkg

//--- bank_addr_gen.sv
// Forms a full file register address from an instruction's address field.
// Assumes combinational use inside the datapath, same clock domain.
`timescale 1ns/10ps
module bank_addr_gen
  import dec_adj_pkg::*;
(
  // Inputs
  input wire logic use_bank,
  input wire logic [BANK_W-1:0] bank_sel,
  input wire logic [FADDR_W-1:0] faddr,
  // Output
  output logic [ADDR_W-1:0] full_addr
);

  // ----------------------------------------------------------------
  // Bank choice
  // ----------------------------------------------------------------
  // Access bank maps low half to bank 0 and high half to the top bank
  always_comb
  begin
    if (use_bank)
      full_addr = {bank_sel, faddr};
    else if (faddr < ACCESS_SPLIT)
      full_addr = {ACCESS_BANK, faddr};
    else
      full_addr = {ACCESS_HIGH_BANK, faddr};
  end

endmodule : bank_addr_gen

//--- bcd_adjust.sv
// Decimal adjust of a packed BCD byte after addition.
// Assumes carry flags from the preceding add are supplied.
`timescale 1ns/10ps
module bcd_adjust
  import dec_adj_pkg::*;
(
  // Inputs
  input wire logic [DATA_W-1:0] din,
  input wire logic carry_in,
  input wire logic digit_carry_flag,
  // Outputs
  output logic [DATA_W-1:0] dout,
  output logic carry_out
);

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [3:0] hi_in;

  // ----------------------------------------------------------------
  // Nibble correction
  // ----------------------------------------------------------------
  // Low carry ripples into high nibble before its own test
  always_comb
  begin
    lo_sum = {1'b0, din[3:0]};
    if ((din[3:0] > BCD_MAX) || digit_carry_flag)
      lo_sum = {1'b0, din[3:0]} + {1'b0, BCD_FIX};
    hi_in = din[7:4] + {3'h0, lo_sum[4]};
    hi_sum = {1'b0, hi_in};
    if ((hi_in > BCD_MAX) || carry_in || (lo_sum[4] && hi_in == 4'h0))
      hi_sum = {1'b0, hi_in} + {1'b0, BCD_FIX};
    dout = {hi_sum[3:0], lo_sum[3:0]};
    carry_out = hi_sum[4] || carry_in || (lo_sum[4] && hi_in == 4'h0);
  end

endmodule : bcd_adjust

//--- tb_top.sv
// Self-checking bench for the decrement / decimal-adjust datapath.
// Assumes dec_adj_core with an APB slave and a synchronous byte file memory.
`timescale 1ns/10ps
module tb_top
  import dec_adj_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  fmem_req_t fmem_req;
  logic [DATA_W-1:0] fmem_rdata;
  logic [DATA_W-1:0] mem [0:4095];
  int fail_count, checks;
  int we_cnt = 0;

  dec_adj_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fmem_req(fmem_req), .fmem_rdata(fmem_rdata), .busy(busy));

  // Clock, 10 ns period
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // File memory: one-cycle synchronous read, write on the pulse
  always @(posedge pclk)
  begin
    fmem_rdata <= mem[fmem_req.addr];
    if (fmem_req.we === 1'b1)
    begin
      mem[fmem_req.addr] <= fmem_req.wdata;
      we_cnt <= we_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // One APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // Polls the busy bit; a hang here is a mismatch, not a stall
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h100;
    while (s[8] !== 1'b0 && n < 20)
    begin
      rd(OFF_STAT, s);
      n++;
    end
    chk({30'h0, s[9:8]}, 32'h2);
  endtask : wait_idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, width masking and an unmapped offset
  task automatic t_reset_regs();
    logic [31:0] r;
    logic e;
    rd(OFF_OPER, r);
    chk(r, 32'h0000_0300); // operand defaults
    rd(OFF_ACC, r);
    chk(r, 32'h0);
    rd(OFF_FLAGS, r);
    chk(r, 32'h0);
    wr(OFF_BANK, 32'hffff_fff5);
    rd(OFF_BANK, r);
    chk(r, 32'h5);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h18, 32'hffff_ffff, r, e);
    chk({31'h0, e}, 32'h1);
  endtask : t_reset_regs

  // Decrement at one address; other address must stay untouched
  task automatic run_dec(input logic [31:0] oper, input logic [11:0] a,
                         input logic [7:0] v, input logic [11:0] other);
    logic [31:0] r, acc0;
    logic [7:0] keep;
    int w0;
    mem[a] = v;
    keep = mem[other];
    w0 = we_cnt;
    rd(OFF_ACC, acc0);
    wr(OFF_OPER, oper);
    wr(OFF_CTRL, 32'h1);
    // Busy is launched at the go edge, so look half a cycle later
    @(negedge pclk);
    chk({31'h0, busy}, 32'h1); // busy while running
    wait_idle();
    chk({31'h0, busy}, 32'h0); // busy released
    rd(OFF_STAT, r);
    chk({24'h0, r[7:0]}, {24'h0, v - 8'h01}); // result of f minus one
    rd(OFF_CTRL, r);
    chk(r, 32'h0); // last op is decrement
    rd(OFF_ACC, r);
    chk(r, oper[8] ? acc0 : {24'h0, v - 8'h01}); // accumulator dest
    chk({24'h0, mem[a]}, {24'h0, oper[8] ? v - 8'h01 : v}); // file dest
    chk(we_cnt - w0, oper[8] ? 32'h1 : 32'h0); // write pulses
    chk({24'h0, mem[other]}, {24'h0, keep}); // bank choice
  endtask : run_dec

  // Decimal adjust with given carries; digit carry must be kept
  task automatic run_adj(input logic [7:0] a, input logic c, input logic dc,
                         input logic [7:0] exp, input logic cexp);
    logic [31:0] r;
    wr(OFF_ACC, {24'h0, a});
    wr(OFF_FLAGS, {30'h0, dc, c});
    wr(OFF_CTRL, 32'h3);
    rd(OFF_ACC, r);
    chk(r, {24'h0, exp}); // nibble adjust
    rd(OFF_FLAGS, r);
    chk(r, {30'h0, dc, cexp}); // carry update
    rd(OFF_CTRL, r);
    chk(r, 32'h1); // last op is adjust
    rd(OFF_STAT, r);
    chk(r, {22'h0, 2'b10, exp}); // done, idle, result
  endtask : run_adj

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // Watchdog; whole run needs well under 2000 cycles
  initial
  begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial
  begin
    fail_count = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    wr(OFF_BANK, 32'h3);
    run_dec(32'h0000_0210, 12'h310, 8'h00, 12'h010); // banked, acc dest
    run_dec(32'h0000_0385, 12'h385, 8'h80, 12'hf85); // banked, file dest
    run_dec(32'h0000_0185, 12'hf85, 8'h42, 12'h385); // access bank high
    run_dec(32'h0000_0020, 12'h020, 8'h01, 12'h320); // access bank low
    run_adj(8'ha5, 1'b0, 1'b0, 8'h05, 1'b1); // high nibble over nine
    run_adj(8'hce, 1'b0, 1'b0, 8'h34, 1'b1); // both nibbles over nine
    run_adj(8'h09, 1'b0, 1'b1, 8'h0f, 1'b0); // digit carry set
    run_adj(8'h12, 1'b1, 1'b0, 8'h72, 1'b1); // carry set
    run_adj(8'h99, 1'b0, 1'b0, 8'h99, 1'b0); // no adjust
    run_adj(8'h9a, 1'b0, 1'b0, 8'h00, 1'b1); // ripple into high
    give_verdict();
  end
endmodule : tb_top
